// file: common/irq_line3_consts.svh
// Offsets, field masks and reset values of the interrupt line 3 register block
`ifndef IRQ_LINE3_CONSTS_SVH
`define IRQ_LINE3_CONSTS_SVH

`define IRQ3_ADDR_W 12
`define IRQ3_RAW_LO_OFS 12'h080
`define IRQ3_RAW_HI_OFS 12'h084
`define IRQ3_STAT_LO_OFS 12'h088
`define IRQ3_STAT_HI_OFS 12'h08C
`define IRQ3_ENSET_LO_OFS 12'h090
`define IRQ3_ENSET_HI_OFS 12'h094
`define IRQ3_ENCLR_LO_OFS 12'h098
`define IRQ3_ENCLR_HI_OFS 12'h09C

`define IRQ3_RESET_VAL 32'h0000_0000

// Implemented bits; the rest read as zero
`define IRQ3_LO_VALID 32'hF1F5_FFFF
`define IRQ3_HI_VALID 32'h03FF_00FF

// Low word: output, parser and encoder events
`define IRQ3_LO_W1C_MASK 32'hF1F0_0000
// Low word: film mode, descriptor and list bits behave as enable set
`define IRQ3_LO_ENVIEW_MASK 32'h0005_FFFF
`define IRQ3_FILM_MODE_BIT 18
`define IRQ3_DESCRIPTOR_BIT 16
`define IRQ3_LIST_LSB 0
`define IRQ3_LIST_W 16

// High word: error and pipeline group, written 1 to clear
`define IRQ3_HI_W1C_MASK 32'h03FF_0000
`define IRQ3_HI_ERR_LSB 16
`define IRQ3_HI_ERR_W 10
// High word: client and channel groups, written 1 to set
`define IRQ3_HI_W1S_MASK 32'h0000_00FF
`define IRQ3_HI_DMA_LSB 0
`define IRQ3_HI_DMA_W 8

`endif

// file: common/irq_line3_pkg.sv
// Types shared by the interrupt line 3 register block
package irq_line3_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [7:0] {
    SEL_RAW_LO = 8'h01,
    SEL_RAW_HI = 8'h02,
    SEL_STAT_LO = 8'h04,
    SEL_STAT_HI = 8'h08,
    SEL_ENSET_LO = 8'h10,
    SEL_ENSET_HI = 8'h20,
    SEL_ENCLR_LO = 8'h40,
    SEL_ENCLR_HI = 8'h80
  } reg_sel_t;

endpackage

// file: rtl/video_irq_line3_enable_status.sv
// Interrupt line 3 raw status, enabled status and enable registers on APB
//
// Function
// - High enabled status 25:16 reads error status
// - Writing 1 there clears pending event
// - High bits 7:0 report client, channel groups
// - Writing 1 to those bits sets status
// - Low bits 18,16 read and set enables
// - Low bits 15:0 are list notify/complete pairs
// - Enable set reads enable, one sets it
// - Enable set low field layout, 27:25 reserved
// - High enabled status at 8Ch, reserved zero
// - Enable set at 90h, all disabled after reset
// - Raw status at 84h, writing one sets
`include "irq_line3_consts.svh"

module video_irq_line3_enable_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`IRQ3_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] event_lo,
  input wire logic [31:0] event_hi,
  output logic irq
);

  irq_line3_pkg::word_t raw_lo_r;
  irq_line3_pkg::word_t raw_lo_nxt;
  irq_line3_pkg::word_t raw_hi_r;
  irq_line3_pkg::word_t raw_hi_nxt;
  irq_line3_pkg::word_t en_lo_r;
  irq_line3_pkg::word_t en_lo_nxt;
  irq_line3_pkg::word_t en_hi_r;
  irq_line3_pkg::word_t en_hi_nxt;
  irq_line3_pkg::word_t prdata_r;
  irq_line3_pkg::word_t prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;

  irq_line3_pkg::reg_sel_t sel;
  logic hit;
  logic wr_go;
  irq_line3_pkg::word_t stat_lo;
  irq_line3_pkg::word_t stat_hi;
  irq_line3_pkg::word_t view_lo;
  irq_line3_pkg::word_t view_hi;

  // Address decode
  always_comb begin
    hit = 1'b1;
    sel = irq_line3_pkg::SEL_RAW_LO;
    if (paddr == `IRQ3_RAW_LO_OFS) begin
      sel = irq_line3_pkg::SEL_RAW_LO;
    end else if (paddr == `IRQ3_RAW_HI_OFS) begin
      sel = irq_line3_pkg::SEL_RAW_HI;
    end else if (paddr == `IRQ3_STAT_LO_OFS) begin
      sel = irq_line3_pkg::SEL_STAT_LO;
    end else if (paddr == `IRQ3_STAT_HI_OFS) begin
      sel = irq_line3_pkg::SEL_STAT_HI;
    end else if (paddr == `IRQ3_ENSET_LO_OFS) begin
      sel = irq_line3_pkg::SEL_ENSET_LO;
    end else if (paddr == `IRQ3_ENSET_HI_OFS) begin
      sel = irq_line3_pkg::SEL_ENSET_HI;
    end else if (paddr == `IRQ3_ENCLR_LO_OFS) begin
      sel = irq_line3_pkg::SEL_ENCLR_LO;
    end else if (paddr == `IRQ3_ENCLR_HI_OFS) begin
      sel = irq_line3_pkg::SEL_ENCLR_HI;
    end else begin
      hit = 1'b0;
    end
  end

  // Write lands on the edge where pready is sampled high
  assign wr_go = psel & penable & pwrite & pready_r & hit;

  assign stat_lo = raw_lo_r & en_lo_r;
  assign stat_hi = raw_hi_r & en_hi_r;

  always_comb begin
    // film mode, descriptor read as enable
    // list pairs share the same view
    view_lo = (stat_lo & ~`IRQ3_LO_ENVIEW_MASK) | (en_lo_r & `IRQ3_LO_ENVIEW_MASK);
    view_hi = stat_hi & `IRQ3_HI_VALID;
  end

  // Event and register update; hardware set wins over software clear
  always_comb begin
    raw_lo_nxt = raw_lo_r;
    raw_hi_nxt = raw_hi_r;
    en_lo_nxt = en_lo_r;
    en_hi_nxt = en_hi_r;
    if (wr_go) begin
      case (sel)
        irq_line3_pkg::SEL_RAW_LO: raw_lo_nxt = raw_lo_r | pwdata;
        irq_line3_pkg::SEL_RAW_HI: raw_hi_nxt = raw_hi_r | pwdata;
        irq_line3_pkg::SEL_STAT_LO: begin
          raw_lo_nxt = raw_lo_r & ~(pwdata & `IRQ3_LO_W1C_MASK);
          en_lo_nxt = en_lo_r | (pwdata & `IRQ3_LO_ENVIEW_MASK);
        end
        irq_line3_pkg::SEL_STAT_HI: begin
          raw_hi_nxt = (raw_hi_r & ~(pwdata & `IRQ3_HI_W1C_MASK)) | (pwdata & `IRQ3_HI_W1S_MASK);
        end
        irq_line3_pkg::SEL_ENSET_LO: en_lo_nxt = en_lo_r | pwdata;
        irq_line3_pkg::SEL_ENSET_HI: en_hi_nxt = en_hi_r | pwdata;
        irq_line3_pkg::SEL_ENCLR_LO: en_lo_nxt = en_lo_r & ~pwdata;
        irq_line3_pkg::SEL_ENCLR_HI: en_hi_nxt = en_hi_r & ~pwdata;
        default: en_hi_nxt = en_hi_r;
      endcase
    end
    raw_lo_nxt = (raw_lo_nxt | event_lo) & `IRQ3_LO_VALID;
    raw_hi_nxt = (raw_hi_nxt | event_hi) & `IRQ3_HI_VALID;
    en_lo_nxt = en_lo_nxt & `IRQ3_LO_VALID;
    en_hi_nxt = en_hi_nxt & `IRQ3_HI_VALID;
    // line high while any status bit
    irq_nxt = |{stat_lo, stat_hi};
  end

  // One wait state keeps read data registered
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~hit;
    prdata_nxt = `IRQ3_RESET_VAL;
    if (psel & penable & ~pready_r & ~pwrite & hit) begin
      case (sel)
        irq_line3_pkg::SEL_RAW_LO: prdata_nxt = raw_lo_r;
        irq_line3_pkg::SEL_RAW_HI: prdata_nxt = raw_hi_r;
        irq_line3_pkg::SEL_STAT_LO: prdata_nxt = view_lo;
        irq_line3_pkg::SEL_STAT_HI: prdata_nxt = view_hi;
        irq_line3_pkg::SEL_ENSET_LO: prdata_nxt = en_lo_r;
        irq_line3_pkg::SEL_ENSET_HI: prdata_nxt = en_hi_r;
        // Clear registers are write only
        default: prdata_nxt = `IRQ3_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_lo_r <= `IRQ3_RESET_VAL;
      raw_hi_r <= `IRQ3_RESET_VAL;
      en_lo_r <= `IRQ3_RESET_VAL;
      en_hi_r <= `IRQ3_RESET_VAL;
      prdata_r <= `IRQ3_RESET_VAL;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      raw_lo_r <= raw_lo_nxt;
      raw_hi_r <= raw_hi_nxt;
      en_lo_r <= en_lo_nxt;
      en_hi_r <= en_hi_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

endmodule // video_irq_line3_enable_status

// file: bench/irq3_properties.sv
// Port checker for the line 3 interrupt registers
module irq3_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && !pwrite;
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready unasked");
  a_refuse_zero: assert property (pslverr |-> pready && prdata == 0)
    else $error("bad refusal");
  a_idle_zero: assert property (!rd |-> prdata == 0)
    else $error("stray data");
  a_stat_resv: assert property (rd && paddr == 12'h08C |-> (prdata & 32'hFC00_FF00) == 0)
    else $error("status reserved set");
  a_raw_resv: assert property (rd && paddr == 12'h084 |-> (prdata & 32'hFC00_FF00) == 0)
    else $error("raw reserved set");
  a_enset_resv: assert property (rd && paddr == 12'h090 |-> (prdata & 32'h0E0A_0000) == 0)
    else $error("enable reserved set");
endmodule // irq3_properties
bind video_irq_line3_enable_status irq3_properties irq3_properties_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr);

// file: bench/event_src.sv
// Model of the video modules raising line 3 events
module event_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic [63:0] pat,
  output logic [31:0] event_lo = 32'h0,
  output logic [31:0] event_hi = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle pulses, idle low between events
  always @(posedge pclk) {event_hi, event_lo} <= go ? pat : 64'h0;
endmodule // event_src

// file: bench/testbench.sv
// Self-checking bench for the line 3 interrupt registers
`include "irq_line3_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, event_lo, event_hi;
  logic [31:0] raw_lo = 0, raw_hi = 0, en_lo = 0, en_hi = 0;
  logic [63:0] pat = 0;
  logic pready, pslverr, irq;
  int miscompares = 0, cmp_count = 0;
  always #4 pclk = ~pclk;
  video_irq_line3_enable_status video_irq_line3_enable_status_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .event_lo, .event_hi, .irq);
  event_src event_src_i (.pclk, .go, .pat, .event_lo, .event_hi);
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("%0d mismatches, %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      12'h080: return raw_lo;
      12'h084: return raw_hi;
      12'h088: return raw_lo & en_lo & `IRQ3_LO_W1C_MASK | en_lo & `IRQ3_LO_ENVIEW_MASK;
      12'h08C: return raw_hi & en_hi;
      12'h090: return en_lo;
      12'h094: return en_hi;
      default: return 32'h0;
    endcase
  endfunction
  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic bad;
    n = 0;
    bad = a > 12'h09C;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1 && ++n < 99);
    chk(pready, 1);
    chk(pslverr, bad);
    chk(prdata, w || bad ? 32'h0 : exp_rd(a));
    if (w && !bad) case (a)
      12'h080: raw_lo |= d & `IRQ3_LO_VALID;
      12'h084: raw_hi |= d & `IRQ3_HI_VALID;
      12'h088: {raw_lo, en_lo} = {raw_lo & ~(d & `IRQ3_LO_W1C_MASK), en_lo | d & `IRQ3_LO_ENVIEW_MASK};
      12'h08C: raw_hi = raw_hi & ~(d & `IRQ3_HI_W1C_MASK) | d & `IRQ3_HI_W1S_MASK;
      12'h090: en_lo |= d & `IRQ3_LO_VALID;
      12'h094: en_hi |= d & `IRQ3_HI_VALID;
      12'h098: en_lo &= ~d;
      12'h09C: en_hi &= ~d;
      default: ;
    endcase
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end
  initial begin
    void'($urandom(31086));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int k = 0; k < 9; k++) op(1'b0, 12'h080 + 12'(4 * k), 32'h0);
    for (int i = 0; i < 600; i++) begin
      if ($urandom % 4 == 0) begin
        pat <= {$urandom, $urandom};
        go <= 1;
        @(posedge pclk) go <= 0;
        repeat (2) @(posedge pclk);
        raw_lo |= pat[31:0] & `IRQ3_LO_VALID;
        raw_hi |= pat[63:32] & `IRQ3_HI_VALID;
      end else op(1'($urandom % 2), 12'h080 + 12'(4 * ($urandom % 9)), $urandom);
      @(posedge pclk);
      chk(irq, |(raw_lo & en_lo | raw_hi & en_hi));
    end
    results();
  end
endmodule // testbench
